//--- rtl/jl_tx.sv
// transmit end: transport packing, scrambler, alignment, 8b10b and apb registers
// How it works
// - pack samples into fields, frames, lanes
// - one mode register picks the lane layout
// - scrambling optional here, forced in 66-bit coding
// - scramble octets before character encoding
// - alignment sequence always goes out unscrambled
// - scramble enable bit, overridden by 66-bit coding
// - receiver self-synchronises its descrambler
// - standard 8b10b with running disparity
// - K clamped to its legal range
// - sysref resets the multiframe counter
// - multiframe lasts F times K octet clocks
// - continuous sysref at multiframe rate submultiple
// - sync low sends K28.5 on all lanes
// - receiver releases sync after four K28.5
// - after sync rises wait multiframe edge
// - four multiframes, K28.0 first, K28.3 last
// - second multiframe carries link configuration
// - receiver buffers lanes, releases them together
// - repeated last octet becomes K28.7 or K28.3
// - scrambled FC or 7C become alignment characters
// - receiver restores alignment characters to data
// - receiver drops sync on misalignment
`timescale 1ns/1ns
`default_nettype none
module jl_tx #(
  parameter int L = jl_pkg::LANES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SYSREF,
  input wire logic [jl_pkg::SMP_MAX*jl_pkg::SMP_W-1:0] SAMPLES,
  output logic SAMPLE_TAKE,
  jl_link_if.tx LINK
);
  import jl_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [2:0] sync_sr;
    logic sync_lv;
    logic [2:0] sref_sr;
    logic sref_lv;
    jl_st_t st;
    logic [1:0] mf;
    logic [1:0] oct;
    logic [10:0] pos;
    logic [1:0] mode;
    logic scramble_enable;
    logic e66;
    logic [8:0] kval;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [SMP_MAX*SMP_W-1:0] frame;
    logic take;
    logic [L-1:0][14:0] scs;
    logic [L-1:0][7:0] last;
    logic [L-1:0] rd;
    logic [L-1:0][9:0] chr;
  } jl_tx_state_t;

  jl_tx_state_t s_q;
  jl_tx_state_t s_d;
  logic [2:0] f;
  logic [8:0] kk;
  logic [10:0] fk;
  logic fend;
  logic mend;
  logic sync_ok;
  logic sync_rise;
  logic sref_rise;
  logic eff_scr;
  logic [7:0] raw;
  logic [7:0] d8;
  logic kb;
  logic [10:0] enc;
  logic [22:0] sc;
  logic [3:0] idx;
  logic [31:0] rval;
  logic hit;

  // octet j of the frame; each sample sits msb-aligned in a wider field
  function automatic logic [7:0] frame_octet(input logic [SMP_MAX*SMP_W-1:0] fr,
                                             input logic [3:0] j);
    logic [SMP_W-1:0] smp;
    logic [FLD_W-1:0] fld;
    smp = fr[int'(j[3:1])*SMP_W +: SMP_W];
    fld = {smp, {(FLD_W-SMP_W){1'b0}}};
    return j[0] ? fld[OCT_W-1:0] : fld[FLD_W-1 -: OCT_W];
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    f = MODE_F[s_q.mode];
    kk = jl_kfix(s_q.kval, f);
    fk = 11'(f * kk);
    fend = (s_q.oct == 2'(f - 3'h1));
    mend = fend && (s_q.pos == fk - 11'h001);
    eff_scr = s_q.scramble_enable | s_q.e66;
    raw = '0;
    d8 = '0;
    kb = 1'b0;
    enc = '0;
    sc = '0;
    idx = '0;
    rval = '0;
    hit = 1'b1;

    // pins: three stages, a level counts once stages two and three agree
    s_d.sync_sr = {s_q.sync_sr[1:0], LINK.sync_n};
    s_d.sref_sr = {s_q.sref_sr[1:0], SYSREF};
    sync_ok = (s_q.sync_sr[1] == s_q.sync_sr[2]);
    sync_rise = sync_ok && s_q.sync_sr[2] && !s_q.sync_lv;
    sref_rise = (s_q.sref_sr[1] == s_q.sref_sr[2]) && s_q.sref_sr[2] && !s_q.sref_lv;
    if (sync_ok) s_d.sync_lv = s_q.sync_sr[2];
    if (s_q.sref_sr[1] == s_q.sref_sr[2]) s_d.sref_lv = s_q.sref_sr[2];

    // apb slave: one wait cycle, answer registered
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    case (PADDR)
      A_CTRL: rval = {23'h0, s_q.e66, 3'h0, s_q.scramble_enable, 2'h0, s_q.mode};
      A_KVAL: rval = {23'h0, s_q.kval};
      A_STAT: begin
        rval = {30'h0, s_q.st};
        rval[STAT_KERR_BIT] = (kk != s_q.kval);
        rval[STAT_SYNC_BIT] = s_q.sync_lv;
      end
      default: hit = 1'b0;
    endcase
    if (PSEL && PENABLE && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !hit;
      s_d.prdata = PWRITE ? 32'h0 : rval;
    end
    if (PSEL && PENABLE && s_q.pready && PWRITE) begin
      if (PADDR == A_CTRL) begin
        s_d.mode = PWDATA[1:0];
        s_d.scramble_enable = PWDATA[CTRL_SCR_BIT];
        s_d.e66 = PWDATA[CTRL_E66_BIT];
      end
      if (PADDR == A_KVAL) s_d.kval = PWDATA[8:0];
    end

    // multiframe clock: octet and position counters, phase set by sysref
    if (sref_rise) begin
      s_d.oct = '0;
      s_d.pos = '0;
    end else begin
      s_d.oct = fend ? 2'h0 : s_q.oct + 2'h1;
      s_d.pos = mend ? 11'h000 : s_q.pos + 11'h001;
    end

    // link handshake
    case (s_q.st)
      ST_CGS: if (sync_rise) s_d.st = ST_WAIT;
      ST_WAIT: begin
        if (!s_q.sync_lv) begin
          s_d.st = ST_CGS;
        end else if (mend) begin
          s_d.st = ST_ILAS;
          s_d.mf = '0;
        end
      end
      ST_ILAS: begin
        if (!s_q.sync_lv) begin
          s_d.st = ST_CGS;
        end else if (mend) begin
          s_d.mf = s_q.mf + 2'h1;
          if (s_q.mf == 2'(ILAS_MFS - 1)) s_d.st = ST_DATA;
        end
      end
      ST_DATA: if (!s_q.sync_lv) s_d.st = ST_CGS;
      default: s_d.st = ST_CGS;
    endcase

    // frame capture at each frame boundary
    s_d.take = 1'b0;
    if (fend) begin
      s_d.frame = SAMPLES;
      s_d.take = (s_d.st == ST_DATA);
    end

    // per lane: choose octet, scramble, alignment marks, encode
    for (int l = 0; l < L; l++) begin
      idx = 4'(l * int'(f) + int'(s_q.oct));
      raw = frame_octet(s_q.frame, idx);
      kb = 1'b1;
      d8 = K28_5;
      if (3'(l) < MODE_L[s_q.mode]) begin
        case (s_q.st)
          ST_ILAS: begin
            kb = 1'b0;
            d8 = s_q.pos[7:0];
            if (s_q.pos == '0) begin
              kb = 1'b1;
              d8 = K28_0;
            end else if (mend) begin
              kb = 1'b1;
              d8 = K28_3;
            end else if (s_q.mf == CFG_MF && s_q.pos == QCHR_POS) begin
              kb = 1'b1;
              d8 = K28_4;
            end else if (s_q.mf == CFG_MF && s_q.pos < 11'(CFG_POS + CFG_LEN)) begin
              d8 = jl_cfg(3'(s_q.pos - 11'(CFG_POS)), s_q.mode, eff_scr, kk);
            end
          end
          ST_DATA: begin
            kb = 1'b0;
            d8 = raw;
            if (eff_scr) begin
              sc = jl_scr(s_q.scs[l], raw, 1'b0);
              s_d.scs[l] = sc[22:8];
              d8 = sc[7:0];
              kb = (mend && d8 == K28_3) || (fend && d8 == K28_7);
            end else if (fend && raw == s_q.last[l]) begin
              kb = 1'b1;
              d8 = mend ? K28_3 : K28_7;
            end
            if (fend) s_d.last[l] = raw;
          end
          default: begin
            s_d.last[l] = '0; // fresh compare and scrambler state per link
            s_d.scs[l] = '0;
          end
        endcase
      end
      enc = jl_enc(d8, kb, s_q.rd[l]);
      s_d.rd[l] = enc[10];
      s_d.chr[l] = enc[9:0];
    end
  end

  // ****************************************************************
  // registers and outputs
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.kval <= KVAL_RST;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign SAMPLE_TAKE = s_q.take;
  assign LINK.lane_char = s_q.chr;
endmodule
`default_nettype wire

//--- rtl/jl_pkg.sv
// shared constants, mode table, line coding and scrambler functions for the lane link
package jl_pkg;
  // ****************************************************************
  // sizes and transport modes
  // ****************************************************************
  localparam int LANES = 2;
  localparam int SMP_W = 12;
  localparam int FLD_W = 16;
  localparam int SMP_MAX = 4;
  localparam int NMODES = 4;
  localparam int OCT_W = 8;
  localparam logic [2:0] MODE_L [NMODES] = '{3'h1, 3'h1, 3'h2, 3'h2};
  localparam logic [2:0] MODE_M [NMODES] = '{3'h1, 3'h2, 3'h2, 3'h2};
  localparam logic [2:0] MODE_S [NMODES] = '{3'h1, 3'h1, 3'h1, 3'h2};
  localparam logic [2:0] MODE_F [NMODES] = '{3'h2, 3'h4, 3'h2, 3'h4};

  // ****************************************************************
  // multiframe, alignment and handshake figures
  // ****************************************************************
  localparam int K_LO_NUM = 17;
  localparam int K_HI_NUM = 1024;
  localparam int K_CAP = 256;
  localparam int ILAS_MFS = 4;
  localparam int CGS_CNT = 4;
  localparam int CFG_POS = 2;
  localparam int CFG_LEN = 6;
  localparam logic [1:0] CFG_MF = 2'h1;
  localparam logic [10:0] QCHR_POS = 11'h001;
  localparam logic [7:0] K28_0 = 8'h1c;
  localparam logic [7:0] K28_3 = 8'h7c;
  localparam logic [7:0] K28_4 = 8'h9c;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_7 = 8'hfc;

  // ****************************************************************
  // register map of the transmit end
  // ****************************************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_KVAL = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam int CTRL_SCR_BIT = 4;
  localparam int CTRL_E66_BIT = 8;
  localparam int STAT_KERR_BIT = 4;
  localparam int STAT_SYNC_BIT = 5;
  localparam logic [8:0] KVAL_RST = 9'h020;

  typedef enum logic [1:0] {
    ST_CGS = 2'b00,
    ST_WAIT = 2'b01,
    ST_ILAS = 2'b10,
    ST_DATA = 2'b11
  } jl_st_t;

  // ****************************************************************
  // 8b10b tables, negative disparity forms, bit 5 / bit 3 sent first
  // ****************************************************************
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [5:0] C6_K28 = 6'h0f;
  localparam logic [5:0] C6_D7 = 6'h38;
  localparam logic [3:0] C4_X3 = 4'hc;
  localparam logic [3:0] C4_A7 = 4'h7;

  // clamp K into its legal range for F octets per frame
  function automatic logic [8:0] jl_kfix(input logic [8:0] k, input logic [2:0] f);
    int lo;
    int hi;
    lo = (K_LO_NUM + int'(f) - 1) / int'(f);
    hi = K_HI_NUM / int'(f);
    if (hi > K_CAP) hi = K_CAP;
    if (int'(k) < lo) return 9'(lo);
    if (int'(k) > hi) return 9'(hi);
    return k;
  endfunction

  // one octet to one character; returns {new disparity, abcdei, fghj}
  function automatic logic [10:0] jl_enc(input logic [7:0] d, input logic k, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic rdm;
    logic alt;
    logic [4:0] x;
    x = d[4:0];
    c6 = k ? C6_K28 : T6[x];
    rdm = ($countones(c6) != 3) ? ~rd : rd;
    if (rd && (($countones(c6) != 3) || (c6 == C6_D7))) c6 = ~c6;
    alt = (d[7:5] == 3'h7) && (k || (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rdm && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
    c4 = alt ? C4_A7 : T4[d[7:5]];
    if (rdm && (($countones(c4) != 2) || (c4 == C4_X3))) c4 = ~c4;
    // control forms other than x.3 flip their neutral fghj after a negative 6b block
    if (k && !rdm && ($countones(c4) == 2) && (c4 != C4_X3)) c4 = ~c4;
    return {(($countones(c4) != 2) ? ~rdm : rdm), c6, c4};
  endfunction

  // character back to octet by search; returns {valid, new disparity, k, octet}
  function automatic logic [10:0] jl_dec(input logic [9:0] c, input logic rd);
    logic [10:0] r;
    logic [10:0] e;
    logic [8:0] v;
    logic [7:0] d;
    r = '0;
    for (int i = 0; i < 264; i++) begin
      v = 9'(i);
      d = v[8] ? {v[2:0], 5'h1c} : v[7:0];
      e = jl_enc(d, v[8], rd);
      if (!r[10] && e[9:0] == c) r = {1'b1, e[10], v[8], d};
    end
    return r;
  endfunction

  // self-synchronous 1 + x^14 + x^15 per octet, msb first; returns {state, octet}
  function automatic logic [22:0] jl_scr(input logic [14:0] s, input logic [7:0] din,
                                         input logic desc);
    logic [14:0] st;
    logic [7:0] o;
    st = s;
    o = '0;
    for (int i = 7; i >= 0; i--) begin
      o[i] = din[i] ^ st[13] ^ st[14];
      st = {st[13:0], desc ? din[i] : o[i]};
    end
    return {st, o};
  endfunction

  // link configuration octets carried in the second alignment multiframe
  function automatic logic [7:0] jl_cfg(input logic [2:0] i, input logic [1:0] mode,
                                        input logic scramble_enable, input logic [8:0] k);
    case (i)
      3'h0: return {5'h0, MODE_L[mode] - 3'h1};
      3'h1: return {5'h0, MODE_F[mode] - 3'h1};
      3'h2: return 8'(k - 9'h001);
      3'h3: return {5'h0, MODE_M[mode] - 3'h1};
      3'h4: return {5'h0, MODE_S[mode] - 3'h1};
      default: return {5'h0, scramble_enable, mode};
    endcase
  endfunction
endpackage

//--- rtl/jl_link_if.sv
// lane characters and the sync handshake between transmit and receive ends
`timescale 1ns/1ns
`default_nettype none
interface jl_link_if #(parameter int L = jl_pkg::LANES);
  logic [L-1:0][9:0] lane_char;
  logic sync_n;
  modport tx (output lane_char, input sync_n);
  modport rx (input lane_char, output sync_n);
endinterface
`default_nettype wire

//--- rtl/jl_rx.sv
// receive end: code group sync, lane release, alignment checks and restore
`timescale 1ns/1ns
`default_nettype none
module jl_rx #(
  parameter int L = jl_pkg::LANES,
  parameter int BUF_DEPTH = 4
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic SYSREF,
  input wire logic [1:0] MODE,
  input wire logic SCR_EN,
  input wire logic [8:0] K_VAL,
  jl_link_if.rx LINK,
  output logic [L-1:0][7:0] RX_DATA,
  output logic RX_VALID,
  output logic RX_FEND,
  output logic LINK_UP,
  output logic CFG_ERR,
  output logic ALIGN_ERR
);
  import jl_pkg::*;

  localparam int AW = $clog2(BUF_DEPTH);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [2:0] sref_sr;
    logic sref_lv;
    jl_st_t st;
    logic [10:0] lpos;
    logic [L-1:0][2:0] cgs;
    logic [L-1:0] seen;
    logic [L-1:0][AW-1:0] wp;
    logic [AW-1:0] rp;
    logic rel;
    logic [L-1:0][BUF_DEPTH-1:0][8:0] buf_m;
    logic [L-1:0] rd;
    logic [1:0] oct;
    logic [10:0] pos;
    logic [1:0] mf;
    logic [L-1:0][14:0] dsc;
    logic [L-1:0][7:0] last;
    logic sync_n;
    logic [L-1:0][7:0] data;
    logic valid;
    logic fend_o;
    logic up;
    logic cfg_err;
    logic al_err;
  } jl_rx_state_t;

  jl_rx_state_t s_q;
  jl_rx_state_t s_d;
  logic [2:0] f;
  logic [8:0] kk;
  logic [10:0] fk;
  logic fend;
  logic mend;
  logic all_cgs;
  logic all_seen;
  logic err;
  logic act;
  logic [10:0] dec;
  logic [8:0] q;
  logic [7:0] x;
  logic [22:0] sc;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    f = MODE_F[MODE];
    kk = jl_kfix(K_VAL, f);
    fk = 11'(f * kk);
    fend = (s_q.oct == 2'(f - 3'h1));
    mend = fend && (s_q.pos == fk - 11'h001);
    all_cgs = 1'b1;
    all_seen = 1'b1;
    err = 1'b0;
    dec = '0;
    q = '0;
    x = '0;
    sc = '0;
    act = 1'b0;
    s_d.valid = 1'b0;
    s_d.fend_o = 1'b0;
    s_d.al_err = 1'b0;

    // sysref pin and own multiframe clock
    s_d.sref_sr = {s_q.sref_sr[1:0], SYSREF};
    if (s_q.sref_sr[1] == s_q.sref_sr[2]) s_d.sref_lv = s_q.sref_sr[2];
    if ((s_q.sref_sr[1] == s_q.sref_sr[2]) && s_q.sref_sr[2] && !s_q.sref_lv) begin
      s_d.lpos = '0;
    end else begin
      s_d.lpos = (s_q.lpos == fk - 11'h001) ? 11'h000 : s_q.lpos + 11'h001;
    end

    // per lane decode, comma count and elastic buffer fill
    for (int l = 0; l < L; l++) begin
      act = 3'(l) < MODE_L[MODE];
      dec = jl_dec(LINK.lane_char[l], s_q.rd[l]);
      if (dec[10]) s_d.rd[l] = dec[9];
      if (dec[8] && dec[7:0] == K28_5) begin
        s_d.cgs[l] = (s_q.cgs[l] == 3'(CGS_CNT)) ? s_q.cgs[l] : s_q.cgs[l] + 3'h1;
      end else begin
        s_d.cgs[l] = '0;
      end
      if (act && s_d.cgs[l] != 3'(CGS_CNT)) all_cgs = 1'b0;
      if ((s_q.st == ST_ILAS || s_q.st == ST_DATA) &&
          (s_q.seen[l] || (dec[8] && dec[7:0] == K28_0))) begin
        s_d.buf_m[l][s_q.wp[l]] = dec[8:0];
        s_d.wp[l] = s_q.wp[l] + AW'(1);
        s_d.seen[l] = 1'b1;
      end
      if (act && !s_d.seen[l]) all_seen = 1'b0;
    end

    // released lanes: frame counters, config check, restore, descramble
    if (s_q.rel) begin
      s_d.rp = s_q.rp + AW'(1);
      s_d.oct = fend ? 2'h0 : s_q.oct + 2'h1;
      s_d.pos = mend ? 11'h000 : s_q.pos + 11'h001;
      for (int l = 0; l < L; l++) begin
        q = s_q.buf_m[l][s_q.rp];
        x = q[7:0];
        if (s_q.st == ST_ILAS && s_q.mf == CFG_MF && s_q.pos >= 11'(CFG_POS) &&
            s_q.pos < 11'(CFG_POS + CFG_LEN) && 3'(l) < MODE_L[MODE] &&
            x != jl_cfg(3'(s_q.pos - 11'(CFG_POS)), MODE, SCR_EN, kk)) begin
          s_d.cfg_err = 1'b1;
        end
        if (s_q.st == ST_DATA) begin
          if (q[8]) begin
            if (!((x == K28_7 && fend) || (x == K28_3 && mend))) err = 1'b1;
            if (!SCR_EN) x = s_q.last[l];
          end
          if (SCR_EN) begin
            sc = jl_scr(s_q.dsc[l], x, 1'b1);
            s_d.dsc[l] = sc[22:8];
            x = sc[7:0];
          end
          if (fend) s_d.last[l] = x;
          s_d.data[l] = x;
        end
      end
      s_d.valid = (s_q.st == ST_DATA);
      s_d.fend_o = (s_q.st == ST_DATA) && fend;
      if (s_q.st == ST_ILAS && mend) begin
        s_d.mf = s_q.mf + 2'h1;
        if (s_q.mf == 2'(ILAS_MFS - 1)) begin
          s_d.st = ST_DATA;
          s_d.up = 1'b1;
        end
      end
    end else if (s_q.st == ST_ILAS && all_seen) begin
      s_d.rel = 1'b1;
    end

    // handshake
    case (s_q.st)
      ST_CGS: if (all_cgs) s_d.st = ST_WAIT;
      ST_WAIT: begin
        if (s_q.lpos == fk - 11'h001) begin
          s_d.st = ST_ILAS;
          s_d.sync_n = 1'b1;
        end
      end
      ST_ILAS, ST_DATA: ;
      default: err = 1'b1;
    endcase
    if (err) begin
      s_d.st = ST_CGS;
      s_d.al_err = 1'b1;
    end
    if (s_d.st == ST_CGS) begin
      s_d.sync_n = 1'b0;
      s_d.seen = '0;
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.rel = 1'b0;
      s_d.oct = '0;
      s_d.pos = '0;
      s_d.mf = '0;
      s_d.up = 1'b0;
      s_d.last = '0;
      s_d.dsc = '0;
      if (s_q.st != ST_CGS) s_d.cfg_err = 1'b0;
    end
  end

  // ****************************************************************
  // registers and outputs
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign LINK.sync_n = s_q.sync_n;
  assign RX_DATA = s_q.data;
  assign RX_VALID = s_q.valid;
  assign RX_FEND = s_q.fend_o;
  assign LINK_UP = s_q.up;
  assign CFG_ERR = s_q.cfg_err;
  assign ALIGN_ERR = s_q.al_err;
endmodule
`default_nettype wire

//--- testbench/jl_link_monitor.sv
// wire checker for the lane link: commas, alignment markers, disparity
`timescale 1ns/1ns
`default_nettype none
module jl_link_monitor #(parameter int L = 2) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [L-1:0][9:0] lane_char,
  input wire logic sync_n
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [9:0] c0;
  logic rr;
  logic [5:0] pos_q;
  logic [2:0] run_q;
  logic lnk_q;
  logic trk_q;
  logic rd_q;
  // match a K28.x character in either disparity
  function automatic logic kx(input logic [9:0] c, input logic [9:0] m);
    return (c == m) || (c == ~m);
  endfunction
  assign c0 = lane_char[0];
  assign rr = kx(c0, 10'h0f4);
  // position in multiframe, comma run length, running disparity
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pos_q <= 6'h00;
      run_q <= 3'h0;
      lnk_q <= 1'b0;
      trk_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      pos_q <= (rr && run_q != 3'h0) ? 6'h01 : pos_q + 6'h01;
      lnk_q <= (rr && run_q != 3'h0) || (lnk_q && sync_n);
      run_q <= !kx(c0, 10'h0fa) ? 3'h0 : (run_q == 3'h7) ? run_q : run_q + 3'h1;
      trk_q <= trk_q || kx(c0, 10'h0fa);
      if ((trk_q || kx(c0, 10'h0fa)) && $countones(c0) != 5) rd_q <= ($countones(c0) == 6);
    end
  end
  sequence s_start;
    rr && run_q != 3'h0;
  endsequence
  sequence s_mf;
    ##63 kx(c0, 10'h0f3) ##1 kx(c0, 10'h0f4);
  endsequence
  a_cgs_comma: assert property (!sync_n [*7] |-> kx(c0, 10'h0fa) && kx(lane_char[L-1], 10'h0fa))
    else $error("comma missing while sync low");
  a_cgs_count: assert property ($rose(sync_n) |-> run_q >= 3'h4)
    else $error("sync released before four commas");
  a_ilas_hold: assert property ($rose(sync_n) |-> !rr [*3])
    else $error("alignment start too soon after sync");
  a_ilas_wait: assert property ($rose(sync_n) |-> ##[3:80] rr)
    else $error("alignment start missing after sync");
  a_ilas_frame: assert property (s_start |-> s_mf ##0 s_mf ##0 s_mf ##63 kx(c0, 10'h0f3))
    else $error("alignment multiframe markers wrong");
  a_cfg_marker: assert property (s_start |-> ##65 kx(c0, 10'h0f2))
    else $error("config marker missing");
  a_mf_marker: assert property (lnk_q && kx(c0, 10'h0f3) |-> pos_q == 6'h3f)
    else $error("multiframe marker misplaced");
  a_frame_marker: assert property (lnk_q && kx(c0, 10'h0f8) |-> pos_q[0])
    else $error("frame marker misplaced");
  a_dc_balance: assert property (trk_q |-> $countones(c0) == 5 ||
    ($countones(c0) == 6 && !rd_q) || ($countones(c0) == 4 && rd_q))
    else $error("running disparity broken");
endmodule
`default_nettype wire

//--- testbench/jesd_8b10b_link_tx_tb_top.sv
// bench joining both link ends: registers, mode sweep, data restore
`timescale 1ns/1ns
`default_nettype none
module jesd_8b10b_link_tx_tb_top;
  import jl_pkg::*;
  localparam logic [11:0] SMPV = 12'hab5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rst_rx_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sysref = 1'b0;
  logic ce = 1'b1;
  logic [SMP_MAX*SMP_W-1:0] smp = {SMP_MAX{SMPV}};
  logic [1:0] rx_mode = 2'h0;
  logic rx_scr = 1'b0;
  logic [8:0] rx_k = 9'h020;
  logic [31:0] prdata, rv;
  logic [1:0][7:0] rx_data;
  logic pready, pslverr, take, rx_valid, rx_fend, link_up, cfg_err, align_err, re;
  int err_count = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  // both ends face each other, checker on the wire
  jl_link_if #(.L(2)) i_jl_link_if();
  jl_tx #(.L(2)) i_jl_tx(.CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SYSREF(sysref), .SAMPLES(smp), .SAMPLE_TAKE(take),
    .LINK(i_jl_link_if));
  jl_rx #(.L(2), .BUF_DEPTH(4)) i_jl_rx(.CLK(clk), .RST_N(rst_rx_n), .CE(ce), .SYSREF(sysref),
    .MODE(rx_mode), .SCR_EN(rx_scr), .K_VAL(rx_k), .LINK(i_jl_link_if), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .RX_FEND(rx_fend), .LINK_UP(link_up), .CFG_ERR(cfg_err),
    .ALIGN_ERR(align_err));
  jl_link_monitor #(.L(2)) i_jl_link_monitor(.CLK(clk), .RST_N(rst_n),
    .lane_char(i_jl_link_if.lane_char), .sync_n(i_jl_link_if.sync_n));
  task automatic close_out();
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic wait_for(input logic s);
    int n = 0;
    while ((s ? cfg_err : link_up) !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if ((s ? cfg_err : link_up) !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic t_regs();
    logic [8:0] kv [4] = '{9'h004, 9'h005, 9'h100, 9'h101};
    logic ke [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    apb(1'b0, A_KVAL, 32'h0);
    chk("kval_rst", {23'h0, KVAL_RST}, rv);
    apb(1'b1, A_CTRL, 32'h0000_0113);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl_rw", 32'h0000_0113, rv);
    foreach (kv[i]) begin
      apb(1'b1, A_KVAL, {23'h0, kv[i]});
      apb(1'b0, A_STAT, 32'h0);
      chk("k_range", 32'(ke[i]), 32'(rv[STAT_KERR_BIT]));
    end
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", 32'h1, 32'(re));
    chk("unmapped_rd", 32'h0, rv);
  endtask
  // rx held in reset forces resync, then the link is brought up in mode m
  task automatic link(input logic [1:0] m, input logic [31:0] ctl, input logic rs, input logic bad);
    int nf = 0;
    int nt = 0;
    int na = 0;
    logic [8:0] k;
    k = 9'(64 / int'(MODE_F[m]));
    rst_rx_n <= 1'b0;
    apb(1'b1, A_CTRL, ctl | 32'(m));
    apb(1'b1, A_KVAL, {23'h0, k});
    rx_mode <= m;
    rx_scr <= rs;
    rx_k <= k;
    apb(1'b0, A_STAT, 32'h0);
    chk("stat_idle", 32'h0, 32'({rv[STAT_SYNC_BIT], rv[1:0]}));
    rst_rx_n <= 1'b1;
    @(posedge clk);
    sysref <= 1'b1;
    repeat (2) @(posedge clk);
    sysref <= 1'b0;
    wait_for(bad);
    chk("cfg_err", 32'(bad), 32'(cfg_err));
    if (!bad) begin
      repeat (100) begin
        @(posedge clk);
        if (rx_valid === 1'b1 && rx_fend === 1'b1) begin
          nf++;
          chk("lane0_end", 32'({SMPV[3:0], 4'h0}), 32'(rx_data[0]));
          if (MODE_L[m] == 3'h2) chk("lane1_end", 32'({SMPV[3:0], 4'h0}), 32'(rx_data[1]));
        end
        nt += int'(take === 1'b1);
        na += int'(align_err === 1'b1);
      end
      chk("frames", 32'h1, 32'(nf > 0));
      chk("takes", 32'h1, 32'(nt > 0));
      chk("align_ok", 32'h0, 32'(na));
      apb(1'b0, A_STAT, 32'h0);
      chk("stat_data", 32'h23, 32'(rv[5:0]));
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    link(2'h0, 32'h0, 1'b0, 1'b0);
    link(2'h1, 32'h1 << CTRL_SCR_BIT, 1'b1, 1'b0);
    link(2'h2, 32'h0, 1'b0, 1'b0);
    link(2'h3, 32'h1 << CTRL_E66_BIT, 1'b1, 1'b0);
    link(2'h0, 32'h0, 1'b1, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
